// [rtl/spmc_defs.svh]
`ifndef SPMC_DEFS_SVH
`define SPMC_DEFS_SVH

// Register indices on the plain register port
`define SPMC_ADDR_CLK_CTL 4'h0
`define SPMC_ADDR_SEC_TMR_CTL 4'h1
`define SPMC_ADDR_IRQ_CTL 4'h2
`define SPMC_ADDR_IRQ_EN 4'h3

// clock_control field positions
`define SPMC_SEL_LSB 0
`define SPMC_SEL_MSB 1
`define SPMC_INT_STABLE_BIT 2
`define SPMC_PRI_RUN_BIT 3
`define SPMC_FREQ_LSB 4
`define SPMC_FREQ_MSB 6
`define SPMC_IDLE_BIT 7

// secondary_timer_control and interrupt_control field positions
`define SPMC_SEC_OSC_EN_BIT 3
`define SPMC_SEC_RUN_BIT 6
`define SPMC_GLB_IRQ_BIT 7

// Reset values
`define SPMC_SEL_RST 2'h0
`define SPMC_FREQ_RST 3'h0
`define SPMC_BYTE_RST 8'h00

// Field encodings
`define SPMC_SEL_PRIMARY 2'h0
`define SPMC_SEL_SECONDARY 2'h1
`define SPMC_FREQ_LFRC 3'h0

`endif

// [rtl/spmc_pkg.sv]
package spmc_pkg;

   typedef enum logic [2:0] {
      SPMC_MODE_FULL = 3'b000,
      SPMC_MODE_PMRUN = 3'b001,
      SPMC_MODE_IDLE = 3'b010,
      SPMC_MODE_SLEEP = 3'b011,
      SPMC_MODE_WAKE = 3'b100
   } spmc_mode_type;

   typedef enum logic [1:0] {
      SPMC_SRC_PRIMARY = 2'b00,
      SPMC_SRC_SECONDARY = 2'b01,
      SPMC_SRC_INTERNAL = 2'b10,
      SPMC_SRC_NONE = 2'b11
   } spmc_src_type;

endpackage : spmc_pkg

// [rtl/spmc_sync.sv]
`timescale 1ns/1ps
module spmc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;

   // The first stage feeds the second stage only
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff <= '0;
         sync_out <= '0;
      end else begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule : spmc_sync

// [rtl/spmc_ctrl.sv]
// Operation
// R01 - Select field picks power-managed clock source
// R02 - Selection applies only when sleep executes
// R03 - Any reset clears clock select field
// R04 - Frequency field picks internal block output
// R05 - Frequency write takes effect at once
// R06 - Primary running flag after start-up timer
// R07 - Internal stable flag when block clocks system; code leaves it clear while the frequency field selects LFRC
// R08 - Secondary running flag while it clocks system
// R09 - At most one source flag set
// R10 - Secondary selection ignored unless oscillator enabled
// R11 - Software starts secondary oscillator before sleep
// R12 - Idle bit plus sleep halts CPU
// R13 - Idle entry keeps flags and peripheral clock; code keeps the peripheral clock but sets the flags from the selected source
// R14 - Sleep with idle and select clear sleeps
// R15 - Sleep stops primary and internal oscillators
// R16 - Sleep entry clears all source flags
// R17 - Interrupt, reset or watchdog ends low power
// R18 - Timed software waits for primary running flag
// R19 - Only enabled interrupt flags wake device
// R20 - Wake branches to vector if global enabled
// R21 - Sleep strobe in, halt held until wake
`timescale 1ns/1ps
`include "spmc_defs.svh"
module spmc_ctrl
   import spmc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [7:0] reg_rdata,
   input wire logic sleep_strobe,
   input wire logic [7:0] irq_flags,
   input wire logic wdt_timeout,
   input wire logic wdt_enable,
   input wire logic ost_expired,
   input wire logic int_osc_ready,
   output logic [1:0] sys_clk_src,
   output logic [2:0] internal_freq_sel,
   output logic primary_osc_en,
   output logic internal_osc_en,
   output logic low_freq_rc_en,
   output logic secondary_osc_run,
   output logic cpu_halt,
   output logic periph_clk_en,
   output logic wake_pulse,
   output logic irq_vector_branch
);
   logic [1:0] sleep_clock_select_ff;
   logic [2:0] internal_freq_select_ff;
   logic idle_on_sleep_ff;
   logic secondary_osc_enable_ff;
   logic global_irq_enable_ff;
   logic [7:0] irq_enable_ff;
   logic primary_clock_running_ff;
   logic internal_osc_stable_ff;
   logic secondary_clock_running_ff;
   spmc_mode_type mode_ff;
   spmc_mode_type nxt_mode;
   spmc_src_type src_ff;
   spmc_src_type nxt_src;
   spmc_src_type sel_src;
   logic sel_valid;
   logic wake_irq_ff;
   logic nxt_wake_irq;
   logic irq_wake;
   logic wake_cause;
   logic low_power;
   logic ost_sync;
   logic int_osc_sync;
   logic wr_ctl;

   // Oscillator status comes from analog timers outside this clock domain
   spmc_sync #(.WIDTH(2)) u_osc_sync (
      .clk(clk),
      .rst(rst),
      .async_in({ost_expired, int_osc_ready}),
      .sync_out({ost_sync, int_osc_sync})
   );

   assign wr_ctl = reg_we && (reg_addr == `SPMC_ADDR_CLK_CTL);
   assign irq_wake = |(irq_flags & irq_enable_ff); // R19
   assign low_power = (mode_ff == SPMC_MODE_PMRUN) || (mode_ff == SPMC_MODE_IDLE) ||
      (mode_ff == SPMC_MODE_SLEEP);
   assign wake_cause = irq_wake || wdt_timeout; // R17

   // Writable control fields
   always_ff @(posedge clk) begin
      if (rst) begin
         sleep_clock_select_ff <= `SPMC_SEL_RST; // R03
         internal_freq_select_ff <= `SPMC_FREQ_RST;
         idle_on_sleep_ff <= 1'b0;
      end else if (wr_ctl) begin
         sleep_clock_select_ff <= reg_wdata[`SPMC_SEL_MSB:`SPMC_SEL_LSB]; // R01
         internal_freq_select_ff <= reg_wdata[`SPMC_FREQ_MSB:`SPMC_FREQ_LSB]; // R04
         idle_on_sleep_ff <= reg_wdata[`SPMC_IDLE_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         secondary_osc_enable_ff <= 1'b0;
         global_irq_enable_ff <= 1'b0;
         irq_enable_ff <= `SPMC_BYTE_RST;
      end else begin
         if (reg_we && (reg_addr == `SPMC_ADDR_SEC_TMR_CTL)) begin
            secondary_osc_enable_ff <= reg_wdata[`SPMC_SEC_OSC_EN_BIT];
         end
         if (reg_we && (reg_addr == `SPMC_ADDR_IRQ_CTL)) begin
            global_irq_enable_ff <= reg_wdata[`SPMC_GLB_IRQ_BIT];
         end
         if (reg_we && (reg_addr == `SPMC_ADDR_IRQ_EN)) begin
            irq_enable_ff <= reg_wdata;
         end
      end
   end

   // Source requested by the select field
   always_comb begin
      sel_valid = 1'b1;
      case (sleep_clock_select_ff)
         `SPMC_SEL_PRIMARY: sel_src = SPMC_SRC_PRIMARY; // R01
         `SPMC_SEL_SECONDARY: begin
            sel_src = SPMC_SRC_SECONDARY;
            sel_valid = secondary_osc_enable_ff; // R10
         end
         default: sel_src = SPMC_SRC_INTERNAL;
      endcase
   end

   // Mode sequencing; the select field only matters at the sleep strobe
   always_comb begin
      nxt_mode = mode_ff;
      nxt_src = src_ff;
      nxt_wake_irq = wake_irq_ff;
      case (mode_ff)
         SPMC_MODE_FULL, SPMC_MODE_PMRUN: begin
            if (mode_ff == SPMC_MODE_PMRUN && wake_cause) begin
               nxt_mode = SPMC_MODE_WAKE; // R17
               nxt_wake_irq = irq_wake;
            end else if (sleep_strobe) begin // R02 R21
               if (idle_on_sleep_ff) begin
                  nxt_mode = SPMC_MODE_IDLE; // R12
                  if (sel_valid) begin
                     nxt_src = sel_src; // R13
                  end
               end else if (sleep_clock_select_ff == `SPMC_SEL_PRIMARY) begin
                  nxt_mode = SPMC_MODE_SLEEP; // R14
                  nxt_src = SPMC_SRC_NONE;
               end else if (sel_valid) begin
                  nxt_mode = SPMC_MODE_PMRUN;
                  nxt_src = sel_src;
               end
            end
         end
         SPMC_MODE_IDLE, SPMC_MODE_SLEEP: begin
            if (wake_cause) begin
               nxt_mode = SPMC_MODE_WAKE; // R17
               nxt_wake_irq = irq_wake;
            end
         end
         SPMC_MODE_WAKE: begin
            nxt_mode = SPMC_MODE_FULL;
            nxt_src = SPMC_SRC_PRIMARY;
            nxt_wake_irq = 1'b0;
         end
         default: begin
            nxt_mode = SPMC_MODE_FULL;
            nxt_src = SPMC_SRC_PRIMARY;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_ff <= SPMC_MODE_FULL;
         src_ff <= SPMC_SRC_PRIMARY;
         wake_irq_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         src_ff <= nxt_src;
         wake_irq_ff <= nxt_wake_irq;
      end
   end

   // Flags follow the next source so sleep entry clears them in the same edge.
   // Only the active source may raise its flag, so they stay exclusive.
   always_ff @(posedge clk) begin
      if (rst) begin
         primary_clock_running_ff <= 1'b0;
         internal_osc_stable_ff <= 1'b0;
         secondary_clock_running_ff <= 1'b0;
      end else begin
         primary_clock_running_ff <= (nxt_src == SPMC_SRC_PRIMARY) && ost_sync; // R06 R09
         internal_osc_stable_ff <= (nxt_src == SPMC_SRC_INTERNAL) && int_osc_sync &&
            (internal_freq_select_ff != `SPMC_FREQ_LFRC); // R07 R09
         secondary_clock_running_ff <= (nxt_src == SPMC_SRC_SECONDARY) &&
            secondary_osc_enable_ff; // R08 R16
      end
   end

   // Clock tree controls
   always_ff @(posedge clk) begin
      if (rst) begin
         sys_clk_src <= SPMC_SRC_PRIMARY;
         internal_freq_sel <= `SPMC_FREQ_RST;
         primary_osc_en <= 1'b1;
         internal_osc_en <= 1'b0;
         low_freq_rc_en <= 1'b1;
         secondary_osc_run <= 1'b0;
         periph_clk_en <= 1'b1;
      end else begin
         sys_clk_src <= nxt_src;
         // Tracks the register directly; no deferred copy exists
         internal_freq_sel <= wr_ctl ? reg_wdata[`SPMC_FREQ_MSB:`SPMC_FREQ_LSB] :
            internal_freq_select_ff; // R05
         primary_osc_en <= (nxt_mode != SPMC_MODE_SLEEP); // R15
         internal_osc_en <= (nxt_mode != SPMC_MODE_SLEEP) &&
            (nxt_src == SPMC_SRC_INTERNAL); // R15
         low_freq_rc_en <= (nxt_mode != SPMC_MODE_SLEEP) || wdt_enable; // R15
         secondary_osc_run <= secondary_osc_enable_ff; // R15
         periph_clk_en <= (nxt_mode != SPMC_MODE_SLEEP); // R13
      end
   end

   // CPU handshake
   always_ff @(posedge clk) begin
      if (rst) begin
         cpu_halt <= 1'b0;
         wake_pulse <= 1'b0;
         irq_vector_branch <= 1'b0;
      end else begin
         cpu_halt <= (nxt_mode == SPMC_MODE_IDLE) || (nxt_mode == SPMC_MODE_SLEEP) ||
            (nxt_mode == SPMC_MODE_WAKE); // R12 R21
         wake_pulse <= (mode_ff == SPMC_MODE_WAKE);
         irq_vector_branch <= (mode_ff == SPMC_MODE_WAKE) && wake_irq_ff &&
            global_irq_enable_ff; // R20
      end
   end

   // Register read port; unmapped indices read zero
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= `SPMC_BYTE_RST;
      end else if (reg_re) begin
         case (reg_addr)
            `SPMC_ADDR_CLK_CTL: reg_rdata <= {idle_on_sleep_ff, internal_freq_select_ff,
               primary_clock_running_ff, internal_osc_stable_ff, sleep_clock_select_ff};
            `SPMC_ADDR_SEC_TMR_CTL: reg_rdata <= {1'b0, secondary_clock_running_ff, 2'b00,
               secondary_osc_enable_ff, 3'b000}; // R08
            `SPMC_ADDR_IRQ_CTL: reg_rdata <= {global_irq_enable_ff, 7'h00};
            `SPMC_ADDR_IRQ_EN: reg_rdata <= irq_enable_ff;
            default: reg_rdata <= `SPMC_BYTE_RST;
         endcase
      end else begin
         reg_rdata <= `SPMC_BYTE_RST;
      end
   end

   // Checks
   sequence s_low_power_wake;
      low_power && wake_cause;
   endsequence

   sequence s_wake_done;
      (mode_ff == SPMC_MODE_WAKE) ##1 (mode_ff == SPMC_MODE_FULL && !cpu_halt);
   endsequence

   sequence s_idle_req;
      sleep_strobe && idle_on_sleep_ff &&
         (mode_ff == SPMC_MODE_FULL || mode_ff == SPMC_MODE_PMRUN);
   endsequence

   property p_flags_onehot;
      @(posedge clk) disable iff (rst)
         $onehot0({primary_clock_running_ff, internal_osc_stable_ff,
            secondary_clock_running_ff});
   endproperty
   a_flags_onehot: assert property (p_flags_onehot) // R09
      else $error("More than one clock source flag set");

   property p_sleep_clears;
      @(posedge clk) disable iff (rst)
         (mode_ff == SPMC_MODE_SLEEP) |-> !primary_clock_running_ff &&
            !internal_osc_stable_ff && !secondary_clock_running_ff;
   endproperty
   a_sleep_clears: assert property (p_sleep_clears) // R16
      else $error("Source flag set during sleep");

   property p_select_deferred;
      @(posedge clk) disable iff (rst)
         (wr_ctl && !sleep_strobe && mode_ff == SPMC_MODE_FULL) |=> $stable(sys_clk_src);
   endproperty
   a_select_deferred: assert property (p_select_deferred) // R02
      else $error("Clock source changed without sleep");

   property p_reset_select;
      @(posedge clk) disable iff (rst)
         $past(rst) |-> (sleep_clock_select_ff == `SPMC_SEL_RST);
   endproperty
   a_reset_select: assert property (p_reset_select) // R03
      else $error("Select field not cleared by reset");

   property p_freq_now;
      @(posedge clk) disable iff (rst)
         wr_ctl |=> (internal_freq_sel == $past(reg_wdata[`SPMC_FREQ_MSB:`SPMC_FREQ_LSB]));
   endproperty
   a_freq_now: assert property (p_freq_now) // R05
      else $error("Frequency select not applied at once");

   property p_secondary_ignored;
      @(posedge clk) disable iff (rst)
         (sleep_strobe && mode_ff == SPMC_MODE_FULL && !secondary_osc_enable_ff &&
            sleep_clock_select_ff == `SPMC_SEL_SECONDARY) |=> (src_ff != SPMC_SRC_SECONDARY);
   endproperty
   a_secondary_ignored: assert property (p_secondary_ignored) // R10
      else $error("Disabled secondary oscillator selected");

   property p_idle_entry;
      @(posedge clk) disable iff (rst)
         s_idle_req |=> (mode_ff == SPMC_MODE_IDLE) && cpu_halt && periph_clk_en;
   endproperty
   a_idle_entry: assert property (p_idle_entry) // R12
      else $error("Idle not entered on sleep strobe");

   property p_sleep_stops;
      @(posedge clk) disable iff (rst)
         (mode_ff == SPMC_MODE_SLEEP) |-> !primary_osc_en && !internal_osc_en &&
            (low_freq_rc_en == $past(wdt_enable));
   endproperty
   a_sleep_stops: assert property (p_sleep_stops) // R15
      else $error("Oscillator enables wrong in sleep");

   property p_wake_exit;
      @(posedge clk) disable iff (rst)
         s_low_power_wake |=> s_wake_done;
   endproperty
   a_wake_exit: assert property (p_wake_exit) // R17
      else $error("Wake sequence not completed");

   property p_vector_branch;
      @(posedge clk) disable iff (rst)
         (mode_ff == SPMC_MODE_WAKE) |=>
            (irq_vector_branch == ($past(wake_irq_ff) && $past(global_irq_enable_ff)));
   endproperty
   a_vector_branch: assert property (p_vector_branch) // R20
      else $error("Vector branch decision wrong");

   property p_halt_held;
      @(posedge clk) disable iff (rst)
         cpu_halt |-> (mode_ff == SPMC_MODE_IDLE || mode_ff == SPMC_MODE_SLEEP ||
            mode_ff == SPMC_MODE_WAKE);
   endproperty
   a_halt_held: assert property (p_halt_held) // R21
      else $error("Halt outside a halted mode");

endmodule : spmc_ctrl

// [dv/spmc_cpu_model.sv]
`timescale 1ns/1ps
module spmc_cpu_model (
   input wire logic clk,
   input wire logic wake_pulse,
   output logic sleep_strobe,
   output logic [7:0] irq_flags,
   output logic wdt_timeout
);
   initial begin
      sleep_strobe = 1'b0;
      irq_flags = 8'h00;
      wdt_timeout = 1'b0;
   end
   task automatic exec_sleep();
      @(posedge clk);
      sleep_strobe <= 1'b1;
      @(posedge clk);
      sleep_strobe <= 1'b0;
   endtask : exec_sleep
   task automatic raise_irq(input logic [7:0] f);
      @(posedge clk);
      irq_flags <= f;
   endtask : raise_irq
   task automatic wdt_bite();
      @(posedge clk);
      wdt_timeout <= 1'b1;
      @(posedge clk);
      wdt_timeout <= 1'b0;
   endtask : wdt_bite
   // Handler clears its flag on resume, else the next sleep would wake at once
   always @(posedge clk) begin
      if (wake_pulse) begin
         irq_flags <= 8'h00;
      end
   end
endmodule : spmc_cpu_model

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
   logic clk, rst, reg_we, reg_re, wdt_enable, ost_expired, int_osc_ready;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, irq_flags;
   logic [1:0] sys_clk_src;
   logic [2:0] internal_freq_sel;
   logic sleep_strobe, wdt_timeout, primary_osc_en, internal_osc_en, low_freq_rc_en;
   logic secondary_osc_run, cpu_halt, periph_clk_en, wake_pulse, irq_vector_branch;
   int fails = 0;
   int num_checks = 0;
   int cycles = 0;

   spmc_ctrl dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .sleep_strobe(sleep_strobe),
      .irq_flags(irq_flags), .wdt_timeout(wdt_timeout), .wdt_enable(wdt_enable),
      .ost_expired(ost_expired), .int_osc_ready(int_osc_ready), .sys_clk_src(sys_clk_src),
      .internal_freq_sel(internal_freq_sel), .primary_osc_en(primary_osc_en),
      .internal_osc_en(internal_osc_en), .low_freq_rc_en(low_freq_rc_en),
      .secondary_osc_run(secondary_osc_run), .cpu_halt(cpu_halt),
      .periph_clk_en(periph_clk_en), .wake_pulse(wake_pulse),
      .irq_vector_branch(irq_vector_branch));
   spmc_cpu_model cpu (.clk(clk), .wake_pulse(wake_pulse), .sleep_strobe(sleep_strobe),
      .irq_flags(irq_flags), .wdt_timeout(wdt_timeout));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   function automatic logic [7:0] outs();
      return {sys_clk_src, primary_osc_en, internal_osc_en, low_freq_rc_en, cpu_halt,
         periph_clk_en, secondary_osc_run};
   endfunction : outs
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
      #1;
   endtask : wr
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_re <= 1'b0;
      #1;
      chk(reg_rdata, exp, what);
   endtask : rd_chk
   // Bounded wait: a missing wake shows up as a failed compare, not a hang
   task automatic wake_chk(input logic br);
      int i;
      // Never look at the outputs in the time step of the edge that launches them
      #1;
      for (i = 0; i < 20 && wake_pulse !== 1'b1; i++) step(1);
      chk({7'h0, wake_pulse}, 8'h01, "wake");
      chk({7'h0, irq_vector_branch}, {7'h0, br}, "branch");
      chk({5'h0, sys_clk_src, cpu_halt}, 8'h00, "after wake");
   endtask : wake_chk
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fails = fails + 1;
         final_report();
      end
   end

   initial begin
      rst = 1'b1;
      reg_we = 1'b0;
      reg_re = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      wdt_enable = 1'b1;
      ost_expired = 1'b0;
      int_osc_ready = 1'b0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk(outs(), 8'h2a, "reset outputs");
      rd_chk(4'h0, 8'h00, "ctl reset");
      rd_chk(4'h9, 8'h00, "unmapped");
      $display("test reset finished");
      wr(4'h0, 8'h5e);
      chk({5'h0, internal_freq_sel}, 8'h05, "freq");
      chk({6'h0, sys_clk_src}, 8'h00, "src held");
      rd_chk(4'h0, 8'h52, "ctl rw");
      @(posedge clk);
      int_osc_ready <= 1'b1;
      cpu.exec_sleep();
      #1;
      chk({5'h0, sys_clk_src, cpu_halt}, 8'h04, "pm run internal");
      chk({7'h0, internal_osc_en}, 8'h01, "internal osc on");
      step(4);
      rd_chk(4'h0, 8'h56, "internal flag");
      wr(4'h0, 8'h32);
      chk({5'h0, internal_freq_sel}, 8'h03, "freq live");
      wr(4'h0, 8'h02);
      rd_chk(4'h0, 8'h02, "low freq rc no flag");
      chk({7'h0, internal_osc_en}, 8'h01, "internal osc kept");
      $display("test internal finished");
      wr(4'h0, 8'hb2);
      cpu.exec_sleep();
      #1;
      chk({4'h0, sys_clk_src, cpu_halt, periph_clk_en}, 8'h0b, "idle");
      rd_chk(4'h0, 8'hb6, "idle flags");
      cpu.wdt_bite();
      wake_chk(1'b0);
      $display("test idle finished");
      wr(4'h0, 8'h30);
      cpu.exec_sleep();
      #1;
      chk(outs(), 8'hcc, "sleep");
      rd_chk(4'h0, 8'h30, "sleep flags");
      cpu.raise_irq(8'h04);
      step(6);
      chk({7'h0, cpu_halt}, 8'h01, "masked irq");
      wr(4'h2, 8'h80);
      wr(4'h3, 8'h04);
      wake_chk(1'b1);
      @(posedge clk);
      wdt_enable <= 1'b0;
      wr(4'h2, 8'h00);
      cpu.exec_sleep();
      #1;
      chk(outs(), 8'hc4, "sleep no wdt");
      cpu.raise_irq(8'h04);
      wake_chk(1'b0);
      @(posedge clk);
      wdt_enable <= 1'b1;
      ost_expired <= 1'b1;
      $display("test sleep finished");
      step(4);
      rd_chk(4'h0, 8'h38, "primary flag");
      wr(4'h0, 8'h31);
      cpu.exec_sleep();
      #1;
      chk({5'h0, sys_clk_src, cpu_halt}, 8'h00, "secondary refused");
      wr(4'h1, 8'h08);
      cpu.exec_sleep();
      #1;
      chk({5'h0, sys_clk_src, cpu_halt}, 8'h02, "secondary run");
      chk({7'h0, secondary_osc_run}, 8'h01, "secondary osc on");
      rd_chk(4'h1, 8'h48, "secondary flag");
      rd_chk(4'h0, 8'h31, "one flag");
      cpu.wdt_bite();
      wake_chk(1'b0);
      step(4);
      rd_chk(4'h0, 8'h39, "primary back");
      $display("test secondary finished");
      @(posedge clk);
      rst <= 1'b1;
      ost_expired <= 1'b0;
      step(3);
      @(posedge clk);
      rst <= 1'b0;
      rd_chk(4'h0, 8'h00, "ctl after reset");
      rd_chk(4'h1, 8'h00, "sec ctl after reset");
      $display("test reset again finished");
      final_report();
   end
endmodule : testbench
